// file: hdl/an_regs_map.svh
// Offsets, field positions, reset values for negotiation registers
`ifndef AN_REGS_MAP_SVH
`define AN_REGS_MAP_SVH
`define IDX_ADV 5'h04
`define IDX_PARTNER 5'h05
`define IDX_EXPANSION 5'h06
`define ADV_WR_MASK 16'h2DFF
`define PARTNER_MASK 16'hE7FF
`define SELECTOR_8023 5'h01
`define ADV_RST_FIXED 16'h0081
`define B_NEXT_PAGE 15
`define B_ACK 14
`define B_RFAULT 13
`define B_ASYM 11
`define B_PAUSE 10
`define B_T4 9
`define B_TX_FD 8
`define B_TX_HD 7
`define B_10_FD 6
`define B_10_HD 5
`define B_PD_FAULT 4
`define B_LP_NP 3
`define B_LOC_NP 2
`define B_PAGE_RX 1
`define B_LP_AN 0
`define LH_PAGE 0
`define LH_PDF 1
`endif

// file: hdl/an_regs_pkg.sv
// Types shared by the negotiation register bank
package an_regs_pkg;
  typedef logic [15:0] word_t;
  typedef logic [4:0] index_t;
  typedef logic [2:0] strap_t;
  typedef enum logic [1:0] {
    AN_IDLE = 2'h0,
    AN_LISTEN = 2'h1,
    AN_DONE = 2'h3
  } an_state_t;
  typedef enum logic [1:0] {
    PAUSE_NONE = 2'h0,
    PAUSE_SYM = 2'h1,
    PAUSE_ASYM = 2'h2
  } pause_t;
endpackage

// file: hdl/lh_flag_if.sv
// Carrier between the bank and its latching-high flags
`timescale 1ns/1ps
`default_nettype none
interface lh_flag_if;
  logic [1:0] live;
  logic [1:0] clear;
  logic [1:0] flags;
  modport bank (output live, output clear, input flags);
  modport flag (input live, input clear, output flags);
endinterface
`default_nettype wire

// file: hdl/lh_flags.sv
// Latching-high status flags with set-over-clear
`timescale 1ns/1ps
`default_nettype none
module lh_flags (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic soft_rst,
  lh_flag_if.flag lh
);
  logic [1:0] flag_reg;
  logic [1:0] flag_next;

  // Live event wins over a read-clear in the same cycle
  always_comb begin
    flag_next = flag_reg;
    for (int i = 0; i < 2; i++) begin
      if (lh.clear[i]) begin
        flag_next[i] = lh.live[i];
      end
      if (lh.live[i]) begin
        flag_next[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      flag_reg <= 2'h0;
    end else if (soft_rst) begin
      flag_reg <= 2'h0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign lh.flags = flag_reg;
endmodule
`default_nettype wire

// file: hdl/an_regs.sv
// Negotiation ability registers with result resolution
// Notes on behaviour
// - Index 4 holds local advertisement; bits 15:14, 12, 9 read zero.
// - Advertised remote fault writable, reset 0; partner fault read-only.
// - Pause field 11:10 resets 00; none, sym, asym, both.
// - Both pause bits advertised still resolve to at most one kind.
// - Advertised bits 8, 6, 5 reset from the mode straps.
// - Advertised 100 half-duplex resets 1; partner copy resets 0.
// - Selector 4:0 resets 00001; writable locally, read-only for partner.
// - Index 5 is read-only partner word; bits 12:11 read zero.
// - Partner next-page bit resets 0; no next-page exchange here.
// - Partner bit 14 sets once a code word arrives, 0 before.
// - Partner bit 10 reports partner pause support, reset 0.
// - Partner bit 9 reports partner T4 ability, reset 0.
// - Partner bits 8, 6, 5 report received abilities, reset 0.
// - Index 6 expansion register; bits 15:5 read zero.
// - Expansion bit 4 latches parallel detection fault.
// - Expansion bit 3 shows partner next-page ability.
// - Expansion bit 2 shows local next-page ability, reads 0.
// - Expansion bit 1 latches reception of a new page.
// - Expansion bit 0 shows partner negotiation ability.
// - Negotiation runs only when enabled; results override manual choices.
// - Complete flag sets when negotiation ends, 0 until then.
`timescale 1ns/1ps
`default_nettype none
`include "an_regs_map.svh"
module an_regs (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic soft_rst,
  input wire an_regs_pkg::strap_t mode_strap,
  input wire an_regs_pkg::index_t mgmt_index,
  input wire logic mgmt_wr,
  input wire logic mgmt_rd,
  input wire an_regs_pkg::word_t mgmt_wdata,
  output an_regs_pkg::word_t mgmt_rdata,
  output logic mgmt_rvalid,
  input wire logic an_enable,
  input wire logic an_restart,
  input wire logic manual_speed_100,
  input wire logic manual_full_duplex,
  input wire logic page_rx_valid,
  input wire an_regs_pkg::word_t page_rx_word,
  input wire logic partner_an_able,
  input wire logic parallel_fault,
  output an_regs_pkg::word_t adv_word,
  output logic an_complete,
  output logic link_speed_100,
  output logic link_full_duplex,
  output an_regs_pkg::pause_t pause_mode
);
  import an_regs_pkg::*;

  lh_flag_if lh ();

  word_t adv_reg;
  word_t adv_next;
  word_t partner_reg;
  word_t partner_next;
  word_t adv_word_reg;
  word_t rdata_reg;
  word_t rdata_next;
  logic rvalid_reg;
  logic strap_taken_reg;
  strap_t strap_reg;
  logic lp_an_reg;
  an_state_t state_reg;
  an_state_t state_next;
  logic complete_reg;
  logic speed_reg;
  logic speed_next;
  logic duplex_reg;
  logic duplex_next;
  pause_t pause_reg;
  pause_t pause_next;
  word_t exp_word;
  logic [3:0] common;
  logic page_ok;
  logic exp_read;
  logic lp_asym_reg;
  logic lp_asym_next;

  // Reset image of the advertisement, straps fill 8, 6 and 5
  function automatic word_t adv_default(input strap_t s);
    word_t w;
    w = `ADV_RST_FIXED;
    w[`B_TX_FD] = s[2];
    w[`B_10_FD] = s[1];
    w[`B_10_HD] = s[0];
    return w;
  endfunction

  // Partner word as stored: reserved and fixed fields masked
  function automatic word_t partner_image(input word_t w);
    word_t p;
    p = w & `PARTNER_MASK;
    p[`B_ACK] = 1'b1;
    return p;
  endfunction

  // Straps are caught by a clock edge after release, never by reset
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      strap_taken_reg <= 1'b0;
      strap_reg <= 3'h0;
    end else if (!strap_taken_reg) begin
      strap_taken_reg <= 1'b1;
      strap_reg <= mode_strap;
    end
  end

  // Advertisement register
  always_comb begin
    adv_next = adv_reg;
    if (!strap_taken_reg) begin
      adv_next = adv_default(mode_strap);
    end else if (soft_rst) begin
      adv_next = adv_default(strap_reg);
    end else if (mgmt_wr && mgmt_index == `IDX_ADV) begin
      adv_next = mgmt_wdata & `ADV_WR_MASK;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      adv_reg <= `ADV_RST_FIXED;
    end else begin
      adv_reg <= adv_next;
    end
  end

  // Word offered to the link follows the register
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      adv_word_reg <= `ADV_RST_FIXED;
    end else begin
      adv_word_reg <= adv_next;
    end
  end

  // A code word counts only once the sequence has left idle
  assign page_ok = page_rx_valid && state_reg != AN_IDLE;
  assign exp_read = mgmt_rd && mgmt_index == `IDX_EXPANSION;

  // Partner register, loaded only by received code words
  always_comb begin
    partner_next = partner_reg;
    if (soft_rst) begin
      partner_next = {11'h000, `SELECTOR_8023};
    end else if (page_ok) begin
      partner_next = partner_image(page_rx_word);
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      partner_reg <= {11'h000, `SELECTOR_8023};
    end else begin
      partner_reg <= partner_next;
    end
  end

  // Partner asym bit reads as reserved, so it is kept aside for pause
  always_comb begin
    lp_asym_next = lp_asym_reg;
    if (soft_rst) begin
      lp_asym_next = 1'b0;
    end else if (page_ok) begin
      lp_asym_next = page_rx_word[`B_ASYM];
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      lp_asym_reg <= 1'b0;
    end else begin
      lp_asym_reg <= lp_asym_next;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      lp_an_reg <= 1'b0;
    end else if (soft_rst) begin
      lp_an_reg <= 1'b0;
    end else begin
      lp_an_reg <= partner_an_able;
    end
  end

  // Latching flags: live events and read-clear
  always_comb begin
    lh.live[`LH_PAGE] = page_ok;
    lh.live[`LH_PDF] = parallel_fault;
    lh.clear[`LH_PAGE] = exp_read && lh.flags[`LH_PAGE];
    lh.clear[`LH_PDF] = exp_read && lh.flags[`LH_PDF];
  end

  lh_flags u_flags (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .soft_rst(soft_rst),
    .lh(lh)
  );

  always_comb begin
    exp_word = 16'h0000;
    exp_word[`B_PD_FAULT] = lh.flags[`LH_PDF];
    exp_word[`B_LP_NP] = partner_reg[`B_NEXT_PAGE];
    exp_word[`B_LOC_NP] = 1'b0;
    exp_word[`B_PAGE_RX] = lh.flags[`LH_PAGE];
    exp_word[`B_LP_AN] = lp_an_reg;
  end

  // Management read port; unmapped indexes read zero
  always_comb begin
    rdata_next = rdata_reg;
    if (mgmt_rd) begin
      case (mgmt_index)
        `IDX_ADV: rdata_next = adv_reg;
        `IDX_PARTNER: rdata_next = partner_reg;
        `IDX_EXPANSION: rdata_next = exp_word;
        default: rdata_next = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_reg <= 16'h0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= mgmt_rd;
    end
  end

  // Negotiation sequence
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      AN_IDLE: begin
        if (an_enable) begin
          state_next = AN_LISTEN;
        end
      end
      AN_LISTEN: begin
        if (page_rx_valid) begin
          state_next = AN_DONE;
        end
      end
      AN_DONE: state_next = AN_DONE;
      default: state_next = AN_IDLE;
    endcase
    // Disable or restart abandons any progress at once
    if (!an_enable || an_restart || soft_rst) begin
      state_next = AN_IDLE;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= AN_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      complete_reg <= 1'b0;
    end else begin
      complete_reg <= state_next == AN_DONE;
    end
  end

  // Highest common ability: 100 full, 100 half, 10 full, 10 half
  assign common = {
    adv_reg[`B_TX_FD] & partner_next[`B_TX_FD],
    adv_reg[`B_TX_HD] & partner_next[`B_TX_HD],
    adv_reg[`B_10_FD] & partner_next[`B_10_FD],
    adv_reg[`B_10_HD] & partner_next[`B_10_HD]
  };

  always_comb begin
    speed_next = manual_speed_100;
    duplex_next = manual_full_duplex;
    pause_next = PAUSE_NONE;
    if (an_enable) begin
      // Stay at 10 half until a result exists
      speed_next = 1'b0;
      duplex_next = 1'b0;
      if (state_next == AN_DONE) begin
        if (common[3]) begin
          speed_next = 1'b1;
          duplex_next = 1'b1;
        end else if (common[2]) begin
          speed_next = 1'b1;
        end else if (common[1]) begin
          duplex_next = 1'b1;
        end
        // One pause kind at most even when both advertised
        if (adv_reg[`B_PAUSE] && partner_next[`B_PAUSE]) begin
          pause_next = PAUSE_SYM;
        end else if (adv_reg[`B_ASYM] && lp_asym_next) begin
          pause_next = PAUSE_ASYM;
        end
        // Pause needs full duplex to mean anything
        if (!duplex_next) begin
          pause_next = PAUSE_NONE;
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      speed_reg <= 1'b0;
      duplex_reg <= 1'b0;
      pause_reg <= PAUSE_NONE;
    end else begin
      speed_reg <= speed_next;
      duplex_reg <= duplex_next;
      pause_reg <= pause_next;
    end
  end

  assign mgmt_rdata = rdata_reg;
  assign mgmt_rvalid = rvalid_reg;
  assign adv_word = adv_word_reg;
  assign an_complete = complete_reg;
  assign link_speed_100 = speed_reg;
  assign link_full_duplex = duplex_reg;
  assign pause_mode = pause_reg;
endmodule
`default_nettype wire

// file: test/an_regs_props.sv
// Port checker for the negotiation register bank
`timescale 1ns/1ps
`default_nettype none
module an_regs_props (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic soft_rst,
  input wire an_regs_pkg::index_t mgmt_index,
  input wire logic mgmt_wr,
  input wire logic mgmt_rd,
  input wire an_regs_pkg::word_t mgmt_wdata,
  input wire an_regs_pkg::word_t mgmt_rdata,
  input wire logic an_enable,
  input wire logic an_restart,
  input wire logic manual_speed_100,
  input wire logic manual_full_duplex,
  input wire logic page_rx_valid,
  input wire an_regs_pkg::word_t adv_word,
  input wire logic an_complete,
  input wire logic link_speed_100,
  input wire logic link_full_duplex,
  input wire an_regs_pkg::pause_t pause_mode
);
  import an_regs_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  chk_adv_reserved: assert property (
    (adv_word & 16'hD200) == 16'h0000)
    else $error("adv reserved bit set");
  chk_adv_write: assert property (mgmt_wr && !soft_rst &&
    mgmt_index == 5'h04 |=> adv_word == ($past(mgmt_wdata) & 16'h2DFF))
    else $error("adv write mismatch");
  chk_exp_reserved: assert property (mgmt_rd && mgmt_index == 5'h06
    |=> mgmt_rdata[15:5] == 11'h000 && !mgmt_rdata[2])
    else $error("expansion reserved bits set");
  chk_partner_reserved: assert property (mgmt_rd &&
    mgmt_index == 5'h05 |=> mgmt_rdata[12:11] == 2'h0)
    else $error("partner reserved bits set");
  chk_pause_single: assert property (pause_mode != 2'h3 &&
    (!link_full_duplex -> pause_mode == PAUSE_NONE))
    else $error("pause resolution bad");
  chk_complete_off: assert property (!an_enable |=> !an_complete)
    else $error("complete without enable");
  chk_manual_follow: assert property (!an_enable && !soft_rst |=>
    link_speed_100 == $past(manual_speed_100) &&
    link_full_duplex == $past(manual_full_duplex))
    else $error("manual selection not followed");
  chk_page_complete: assert property ($past(an_enable) &&
    $past(arst_n) && !$past(soft_rst) && !$past(an_restart) &&
    an_enable && page_rx_valid && !soft_rst && !an_restart |=> an_complete)
    else $error("page did not complete");
endmodule
`default_nettype wire

// file: test/an_partner.sv
// Link partner model feeding received code words
`timescale 1ns/1ps
`default_nettype none
module an_partner (
  input wire logic core_clk,
  output logic page_rx_valid,
  output an_regs_pkg::word_t page_rx_word,
  output logic partner_an_able
);
  import an_regs_pkg::*;
  initial begin
    page_rx_valid = 1'b0;
    page_rx_word = 16'h0000;
    partner_an_able = 1'b0;
  end
  task automatic set_able(input logic b);
    partner_an_able = b;
  endtask
  // Idle word line toggles so stale data never looks valid
  task automatic send(input word_t w, input int gap);
    repeat (gap) begin
      @(posedge core_clk);
      #1 page_rx_word = ~page_rx_word;
    end
    @(posedge core_clk);
    #1 page_rx_valid = 1'b1;
    page_rx_word = w;
    @(posedge core_clk);
    #1 page_rx_valid = 1'b0;
    page_rx_word = ~w;
  endtask
endmodule
`default_nettype wire

// file: test/autoneg_ability_registers_tb_top.sv
// Bench for the negotiation register bank
`timescale 1ns/1ps
`default_nettype none
`include "an_regs_map.svh"
module autoneg_ability_registers_tb_top;
  import an_regs_pkg::*;
  logic core_clk = 1'b0, arst_n = 1'b0, soft_rst = 1'b0, mgmt_wr = 1'b0;
  logic mgmt_rd = 1'b0, an_enable = 1'b0, an_restart = 1'b0;
  logic manual_speed_100 = 1'b0, manual_full_duplex = 1'b0;
  logic parallel_fault = 1'b0, page_rx_valid, partner_an_able;
  logic mgmt_rvalid, an_complete, link_speed_100, link_full_duplex;
  strap_t mode_strap = 3'h0;
  index_t mgmt_index = 5'h00;
  word_t mgmt_wdata = 16'h0000, mgmt_rdata, page_rx_word, adv_word;
  pause_t pause_mode;
  word_t rnd = 16'h0004, d, w, a, exp_adv;
  logic [3:0] r;
  int err_count = 0, checks_done = 0;
  an_regs DUT (.core_clk, .arst_n, .soft_rst, .mode_strap, .mgmt_index,
    .mgmt_wr, .mgmt_rd, .mgmt_wdata, .mgmt_rdata, .mgmt_rvalid, .an_enable,
    .an_restart, .manual_speed_100, .manual_full_duplex, .page_rx_valid,
    .page_rx_word, .partner_an_able, .parallel_fault, .adv_word,
    .an_complete, .link_speed_100, .link_full_duplex, .pause_mode);
  an_partner lp (.core_clk, .page_rx_valid, .page_rx_word, .partner_an_able);
  always #2 core_clk = ~core_clk;
  function automatic word_t lfsr(input word_t s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Priority 100FD, 100HD, 10FD, 10HD; pause only at full duplex
  function automatic logic [3:0] resolve(input word_t a, input word_t w);
    word_t c;
    logic fd;
    c = a & w;
    fd = c[8] | (!c[7] & c[6]);
    return {c[8] | c[7], fd, fd & c[10] ? 2'h1 : (fd & c[11] ? 2'h2 : 2'h0)};
  endfunction
  task automatic chk(input string n, input word_t seen, input word_t exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wr(input index_t i, input word_t v);
    @(posedge core_clk);
    #1 mgmt_wr = 1'b1;
    mgmt_index = i;
    mgmt_wdata = v;
    @(posedge core_clk);
    #1 mgmt_wr = 1'b0;
  endtask
  task automatic rc(input index_t i, input word_t e, input string n);
    @(posedge core_clk);
    #1 mgmt_rd = 1'b1;
    mgmt_index = i;
    @(posedge core_clk);
    #1 mgmt_rd = 1'b0;
    chk("rvalid", 16'(mgmt_rvalid), 16'h0001);
    chk(n, mgmt_rdata, e);
  endtask
  initial begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    end_sim();
  end
  initial begin
    mode_strap = rnd[2:0];
    repeat (8) @(posedge core_clk);
    #1 arst_n = 1'b1;
    exp_adv = 16'h0081 | {7'h00, mode_strap[2], 1'b0, mode_strap[1:0], 5'h00};
    rc(`IDX_ADV, exp_adv, "adv reset");
    rc(`IDX_PARTNER, 16'h0001, "partner reset");
    rc(`IDX_EXPANSION, 16'h0000, "exp reset");
    rc(5'h07, 16'h0000, "unmapped");
    for (int k = 0; k < 6; k++) begin
      rnd = lfsr(rnd);
      wr(`IDX_ADV, rnd);
      rc(`IDX_ADV, rnd & 16'h2DFF, "adv write");
      wr(`IDX_PARTNER, ~rnd);
      rc(`IDX_PARTNER, 16'h0001, "partner ro");
    end
    lp.set_able(1'b1);
    for (int k = 0; k < 8; k++) begin
      rnd = lfsr(rnd);
      w = (k == 0) ? 16'hFFFF : lfsr(rnd);
      a = (rnd & 16'h21E0) | (16'(k % 4) << 10) | 16'h0001;
      if (k == 0)
        a = 16'h2DE1;
      if (k == 2) begin
        a = 16'h0901;
        w = w | 16'h0900;
      end
      manual_speed_100 = w[3];
      manual_full_duplex = w[2];
      wr(`IDX_ADV, a);
      chk("manual", {12'h000, link_speed_100,
        link_full_duplex, pause_mode}, {12'h000, w[3:2], 2'h0});
      chk("complete off", 16'(an_complete), 16'h0000);
      an_enable = 1'b1;
      lp.send(w, k % 3);
      r = resolve(a, w);
      chk("complete", 16'(an_complete), 16'h0001);
      chk("result", {12'h000, link_speed_100,
        link_full_duplex, pause_mode}, {12'h000, r});
      rc(`IDX_PARTNER, (w | 16'h4000) & 16'hE7FF, "partner");
      rc(`IDX_EXPANSION, {12'h000, w[15], 3'h3}, "exp page");
      rc(`IDX_EXPANSION, {12'h000, w[15], 3'h1}, "exp reread");
      an_enable = 1'b0;
    end
    @(posedge core_clk);
    #1 parallel_fault = 1'b1;
    @(posedge core_clk);
    #1 parallel_fault = 1'b0;
    rc(`IDX_EXPANSION, {11'h000, 1'b1, w[15], 3'h1}, "pd fault");
    rc(`IDX_EXPANSION, {12'h000, w[15], 3'h1}, "pd reread");
    @(posedge core_clk);
    #1 an_enable = 1'b1;
    lp.send(w, 1);
    chk("pre restart", 16'(an_complete), 16'h0001);
    an_restart = 1'b1;
    @(posedge core_clk);
    #1 an_restart = 1'b0;
    chk("restart", {11'h000, an_complete, link_speed_100,
      link_full_duplex, pause_mode}, 16'h0000);
    an_enable = 1'b0;
    lp.set_able(1'b0);
    @(posedge core_clk);
    #1 soft_rst = 1'b1;
    @(posedge core_clk);
    #1 soft_rst = 1'b0;
    rc(`IDX_ADV, exp_adv, "adv soft");
    rc(`IDX_PARTNER, 16'h0001, "partner soft");
    rc(`IDX_EXPANSION, 16'h0000, "exp soft");
    end_sim();
  end
endmodule
bind an_regs an_regs_props props_i (.core_clk, .arst_n, .soft_rst,
  .mgmt_index, .mgmt_wr, .mgmt_rd, .mgmt_wdata, .mgmt_rdata, .an_enable,
  .an_restart, .manual_speed_100, .manual_full_duplex, .page_rx_valid,
  .adv_word, .an_complete, .link_speed_100, .link_full_duplex, .pause_mode);
`default_nettype wire
